// File: inc/sfft_pkg.sv
// Shared constants and types for the streaming transform core.
package sfft_pkg;

  // Sample, twiddle and transform size limits.
  localparam int DATA_W = 16;
  localparam int TW_W = 16;
  localparam int MIN_LOG = 3;
  localparam int MAX_LOG = 16;

  // Rotation engine: angle is a fraction of a full turn on ANG_W bits.
  localparam int ANG_W = 24;
  localparam int CORDIC_N = 14;
  localparam logic [ANG_W-1:0] HALF_TURN = 24'h800000;
  localparam logic [TW_W-1:0] CORDIC_GAIN = 16'h26dd;
  localparam logic [ANG_W-1:0] ATAN_TAB [CORDIC_N] = '{
    24'h200000, 24'h12e405, 24'h09fb38, 24'h051112, 24'h028b0d, 24'h0145d7, 24'h00a2f6,
    24'h00517c, 24'h0028be, 24'h00145f, 24'h000a30, 24'h000518, 24'h00028c, 24'h000146};

  // Register map, one aligned word each.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_MASK = 8'h08;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_BITREV_BIT = 1;
  localparam int ST_DONE_BIT = 0;
  localparam int ST_OVF_BIT = 1;
  localparam int ST_CFG_BIT = 2;
  localparam logic [31:0] CTRL_RST = 32'h00000001;
  localparam logic [31:0] MASK_RST = 32'h00000000;

  // Complex sample, real and imaginary of the same format.
  // Only the fixed-point form is built; a float sample would need its own arithmetic path.
  typedef struct packed {
    logic signed [DATA_W-1:0] re;
    logic signed [DATA_W-1:0] im;
  } sfft_cplx_t;

  // Configuration word: scaling schedule, direction, log2 size, prefix length.
  typedef struct packed {
    logic [2*MAX_LOG-1:0] scale_sch;
    logic inverse_transform;
    logic [4:0] nfft;
    logic [MAX_LOG-1:0] prefix_length;
  } sfft_cfg_t;

  localparam sfft_cfg_t CFG_RST = '{scale_sch: 32'h00000000, inverse_transform: 1'b0,
                                    nfft: 5'h3, prefix_length: 16'h0000};

  // Output beat: sample, its bin number and the frame overflow flag.
  typedef struct packed {
    sfft_cplx_t data;
    logic [MAX_LOG-1:0] output_bin_index;
    logic overflow_flag;
  } sfft_out_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LOAD = 3'b001,
    ST_TW = 3'b010,
    ST_BF = 3'b011,
    ST_UNLOAD = 3'b100
  } sfft_state_t;

endpackage

// File: rtl/sfft_bfly.sv
// Radix-2 butterfly with per-stage scaling and wrap detection.
`timescale 1ns/10ps
module sfft_bfly
  import sfft_pkg::*;
(
  input wire sfft_cplx_t a_in,
  input wire sfft_cplx_t b_in,
  input wire sfft_cplx_t w_in,
  input wire logic [1:0] shift_in,
  output sfft_cplx_t p_out,
  output sfft_cplx_t q_out,
  output logic ovf_out
);

  // Scale down, keep the low bits so a too-large result wraps; flag it.
  function automatic logic [DATA_W:0] scl(input logic signed [DATA_W+2:0] x, input logic [1:0] sh);
    logic signed [DATA_W+2:0] y;
    y = x >>> sh;
    scl = {(y[DATA_W+2:DATA_W-1] != {4{y[DATA_W-1]}}), y[DATA_W-1:0]};
  endfunction

  logic signed [DATA_W+TW_W:0] pr;
  logic signed [DATA_W+TW_W:0] pi;
  logic signed [DATA_W+1:0] tr;
  logic signed [DATA_W+1:0] ti;
  logic [DATA_W:0] r0, r1, r2, r3;

  // Twiddle product in Q2.14, then sum and difference at full width.
  always_comb begin
    pr = $signed(b_in.re) * $signed(w_in.re) - $signed(b_in.im) * $signed(w_in.im);
    pi = $signed(b_in.re) * $signed(w_in.im) + $signed(b_in.im) * $signed(w_in.re);
    tr = pr[TW_W-2 +: DATA_W+2];
    ti = pi[TW_W-2 +: DATA_W+2];
    r0 = scl({{3{a_in.re[DATA_W-1]}}, a_in.re} + {tr[DATA_W+1], tr}, shift_in);
    r1 = scl({{3{a_in.im[DATA_W-1]}}, a_in.im} + {ti[DATA_W+1], ti}, shift_in);
    r2 = scl({{3{a_in.re[DATA_W-1]}}, a_in.re} - {tr[DATA_W+1], tr}, shift_in);
    r3 = scl({{3{a_in.im[DATA_W-1]}}, a_in.im} - {ti[DATA_W+1], ti}, shift_in);
    p_out = '{re: r0[DATA_W-1:0], im: r1[DATA_W-1:0]};
    q_out = '{re: r2[DATA_W-1:0], im: r3[DATA_W-1:0]};
    ovf_out = r0[DATA_W] | r1[DATA_W] | r2[DATA_W] | r3[DATA_W];
  end

endmodule

// File: rtl/sfft_core.sv
// Streaming radix-2 transform core with stream channels and register slave.
//
// Function
// - Forward or inverse transform, 8 to 65536 points.
// - Complex two's complement samples, 8 to 34 bits; this core fixes DATA_W at 16.
// - Twiddle width configurable from 8 to 34 bits; this core fixes TW_W at 16.
// - Float mode: 32-bit parts, 24/25-bit twiddles; not built here, samples are fixed-point only.
// - Forward bins use negative exponent kernel.
// - Inverse uses positive exponent and 1/N.
// - Cooley-Tukey decomposition on powers of two.
// - All transfers over stream channels.
// - Reset beats enable; hold two cycles.
// - Prefix: last L samples, then frame; this core drops the prefix when the bin index is bit reversed.
// - Overflow flag high while unloading overflowed frame.
// - Output bin index natural or bit reversed.
//
// The register addresses and register access over Wishbone were chosen for this implementation.
`timescale 1ns/10ps
module sfft_core
  import sfft_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic s_config_tvalid_in,
  input wire sfft_cfg_t s_config_tdata_in,
  output logic s_config_tready_out,
  input wire logic s_data_tvalid_in,
  input wire sfft_cplx_t s_data_tdata_in,
  output logic s_data_tready_out,
  output logic m_data_tvalid_out,
  output sfft_out_t m_data_tdata_out,
  output logic m_data_tlast_out,
  input wire logic m_data_tready_in,
  output logic irq_out
);

  typedef struct packed {
    sfft_state_t state;
    sfft_cfg_t cfg;
    sfft_cfg_t pend;
    logic pend_valid;
    logic [MAX_LOG+1:0] cnt;
    logic [4:0] stage;
    logic [MAX_LOG-1:0] bf;
    logic tw_started;
    sfft_cplx_t w;
    logic ovf;
    logic out_valid;
    sfft_out_t out;
    logic out_last;
    logic [31:0] ctrl;
    logic [31:0] status;
    logic [31:0] mask;
    logic ack;
    logic [31:0] rdata;
  } sfft_core_st_t;

  sfft_core_st_t q, d;

  // Sample store; the whole frame is transformed in place.
  sfft_cplx_t mem [1 << MAX_LOG];

  // Reverse the low m bits of an address.
  function automatic logic [MAX_LOG-1:0] brev(input logic [MAX_LOG-1:0] v, input logic [4:0] m);
    logic [MAX_LOG-1:0] r;
    for (int i = 0; i < MAX_LOG; i++) begin
      r[i] = v[MAX_LOG-1-i];
    end
    brev = r >> (5'(MAX_LOG) - m);
  endfunction

  logic en;
  logic bitrev;
  logic [MAX_LOG+1:0] npts;
  logic [MAX_LOG+1:0] plen;
  logic [MAX_LOG+1:0] total;
  logic [MAX_LOG+1:0] nat_idx;
  logic [MAX_LOG-1:0] out_idx;
  logic [MAX_LOG-1:0] h;
  logic [MAX_LOG-1:0] j;
  logic [MAX_LOG-1:0] top;
  logic [MAX_LOG-1:0] bot;
  logic [MAX_LOG-1:0] phase;
  logic [1:0] shift;
  logic we0, we1;
  logic [MAX_LOG-1:0] a0, a1;
  sfft_cplx_t d0, d1;
  sfft_cplx_t bf_p, bf_q;
  logic bf_ovf;
  sfft_cplx_t tw_w;
  logic tw_done;
  logic tw_start;
  logic rd_stat;
  logic [31:0] st_set;
  logic cfg_xfer;
  logic [4:0] m_new;
  logic [MAX_LOG+1:0] n_new;

  // Frame geometry and butterfly addressing derived from the active word.
  always_comb begin
    en = q.ctrl[CTRL_EN_BIT];
    bitrev = q.ctrl[CTRL_BITREV_BIT];
    npts = (MAX_LOG+2)'(1) << q.cfg.nfft;
    plen = bitrev ? '0 : {2'b00, q.cfg.prefix_length};
    total = npts + plen;
    nat_idx = (q.cnt < plen) ? (npts - plen + q.cnt) : (q.cnt - plen);
    out_idx = bitrev ? brev(q.cnt[MAX_LOG-1:0], q.cfg.nfft) : nat_idx[MAX_LOG-1:0];
    h = (MAX_LOG)'(1) << q.stage;
    j = q.bf & (h - (MAX_LOG)'(1));
    top = ((q.bf >> q.stage) << (q.stage + 5'h01)) | j;
    bot = top | h;
    phase = j << (5'(MAX_LOG - 1) - q.stage);
    shift = q.cfg.inverse_transform ? 2'h1 : q.cfg.scale_sch[{q.stage[3:0], 1'b0} +: 2];
  end

  // Inverse conjugates the kernel; forward rotates by a negative angle.
  sfft_twid u_twid (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .start_in(tw_start),
    .angle_in(q.cfg.inverse_transform ? phase : -phase),
    .w_out(tw_w),
    .done_out(tw_done)
  );

  sfft_bfly u_bfly (
    .a_in(mem[top]),
    .b_in(mem[bot]),
    .w_in(q.w),
    .shift_in(shift),
    .p_out(bf_p),
    .q_out(bf_q),
    .ovf_out(bf_ovf)
  );

  // Stream readiness; the pending slot is a one-deep holding register.
  assign s_config_tready_out = en && !q.pend_valid;
  assign s_data_tready_out = en && (q.state == ST_LOAD);
  assign cfg_xfer = s_config_tvalid_in && s_config_tready_out;

  // Clamp an out-of-range size and a prefix that would not fit the frame.
  always_comb begin
    m_new = q.pend.nfft;
    if (m_new < 5'(MIN_LOG)) begin
      m_new = 5'(MIN_LOG);
    end else if (m_new > 5'(MAX_LOG)) begin
      m_new = 5'(MAX_LOG);
    end
    n_new = (MAX_LOG+2)'(1) << m_new;
  end

  // Next-state logic for bus slave, stream channels and the engine.
  always_comb begin
    d = q;
    we0 = 1'b0;
    we1 = 1'b0;
    a0 = top;
    a1 = bot;
    d0 = bf_p;
    d1 = bf_q;
    tw_start = 1'b0;
    rd_stat = 1'b0;
    st_set = '0;
    d.ack = 1'b0;
    // Single-cycle answer; unmapped offsets read zero and ignore writes.
    if (wb_cyc_in && wb_stb_in && !q.ack) begin
      d.ack = 1'b1;
      d.rdata = '0;
      case (wb_adr_in)
        REG_CTRL: begin
          d.rdata = q.ctrl;
          if (wb_we_in && wb_sel_in[0]) begin
            d.ctrl = {30'h0, wb_dat_in[1:0]};
          end
        end
        REG_STATUS: begin
          d.rdata = {25'h0, q.state, 1'b0, q.status[2:0]};
          rd_stat = !wb_we_in;
        end
        REG_MASK: begin
          d.rdata = q.mask;
          if (wb_we_in && wb_sel_in[0]) begin
            d.mask = {29'h0, wb_dat_in[2:0]};
          end
        end
        default: d.rdata = '0;
      endcase
    end
    // The enable freezes the engine; reset still wins since it is asynchronous.
    if (en) begin
      if (cfg_xfer) begin
        d.pend = s_config_tdata_in;
        d.pend_valid = 1'b1;
      end
      case (q.state)
        ST_IDLE: begin
          // Only here, between frames, does a waiting word become active.
          if (q.pend_valid) begin
            d.cfg = q.pend;
            d.cfg.nfft = m_new;
            if ({2'b00, q.pend.prefix_length} >= n_new) begin
              d.cfg.prefix_length = n_new[MAX_LOG-1:0] - (MAX_LOG)'(1);
            end
            d.pend_valid = 1'b0;
            st_set[ST_CFG_BIT] = 1'b1;
          end
          d.cnt = '0;
          d.ovf = 1'b0;
          d.state = ST_LOAD;
        end
        ST_LOAD: begin
          // Samples land in bit-reversed slots so the output ends up natural.
          if (s_data_tvalid_in) begin
            we0 = 1'b1;
            a0 = brev(q.cnt[MAX_LOG-1:0], q.cfg.nfft);
            d0 = s_data_tdata_in;
            d.cnt = q.cnt + 1'b1;
            if (q.cnt == npts - 1'b1) begin
              d.cnt = '0;
              d.stage = '0;
              d.bf = '0;
              d.state = ST_TW;
            end
          end
        end
        ST_TW: begin
          if (!q.tw_started) begin
            tw_start = 1'b1;
            d.tw_started = 1'b1;
          end else if (tw_done) begin
            d.w = tw_w;
            d.tw_started = 1'b0;
            d.state = ST_BF;
          end
        end
        ST_BF: begin
          we0 = 1'b1;
          we1 = 1'b1;
          d.ovf = q.ovf | bf_ovf;
          d.bf = q.bf + 1'b1;
          d.state = ST_TW;
          if ({2'b00, q.bf} == (npts >> 1) - 1'b1) begin
            d.bf = '0;
            if (q.stage == q.cfg.nfft - 5'h01) begin
              d.cnt = '0;
              d.state = ST_UNLOAD;
            end else begin
              d.stage = q.stage + 5'h01;
            end
          end
        end
        ST_UNLOAD: begin
          // Output register refills only when empty or being taken.
          if (!q.out_valid || m_data_tready_in) begin
            if (q.cnt < total) begin
              d.out.data = mem[out_idx];
              d.out.output_bin_index = out_idx;
              d.out.overflow_flag = q.ovf;
              d.out_last = (q.cnt == total - 1'b1);
              d.out_valid = 1'b1;
              d.cnt = q.cnt + 1'b1;
            end else begin
              d.out_valid = 1'b0;
              d.out_last = 1'b0;
              d.state = ST_IDLE;
              st_set[ST_DONE_BIT] = 1'b1;
              st_set[ST_OVF_BIT] = q.ovf;
            end
          end
        end
        default: d.state = ST_IDLE;
      endcase
    end
    // A new event in the clearing read survives it.
    d.status = (rd_stat ? '0 : q.status) | st_set;
  end

  // Memory has two write ports, used together only by a butterfly.
  always_ff @(posedge mclk_in) begin
    if (we0) begin
      mem[a0] <= d0;
    end
    if (we1) begin
      mem[a1] <= d1;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      q <= '0;
      q.ctrl <= CTRL_RST;
      q.mask <= MASK_RST;
      q.cfg <= CFG_RST;
    end else begin
      q <= d;
    end
  end

  // Outputs all come from the registered state.
  assign wb_dat_out = q.rdata;
  assign wb_ack_out = q.ack;
  assign m_data_tvalid_out = q.out_valid;
  assign m_data_tdata_out = q.out;
  assign m_data_tlast_out = q.out_last;
  assign irq_out = |(q.status & q.mask);

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  a_cfg_hold_frame: assert property ((q.state != ST_IDLE && $past(q.state) != ST_IDLE)
    |-> $stable(q.cfg))
    else $error("active configuration changed inside a frame");

  a_size_in_range: assert property (q.cfg.nfft >= 5'(MIN_LOG) && q.cfg.nfft <= 5'(MAX_LOG))
    else $error("transform size outside supported range");

  a_out_beat_hold: assert property ((m_data_tvalid_out && !m_data_tready_in)
    |=> (m_data_tvalid_out && $stable(m_data_tdata_out)))
    else $error("output beat dropped or changed before acceptance");

  a_load_frame_end: assert property ((en && q.state == ST_LOAD && s_data_tvalid_in && q.cnt == npts - 1'b1)
    |=> (q.state == ST_TW && q.stage == 5'h00))
    else $error("engine did not start after last sample of frame");

  a_prefix_first: assert property ((en && q.state == ST_UNLOAD && q.cnt == '0 && plen != '0 && !q.out_valid)
    |=> (m_data_tdata_out.output_bin_index == 16'(npts - plen)))
    else $error("prefix does not start at the frame tail");

  a_ovf_frame: assert property ((q.state == ST_UNLOAD && m_data_tvalid_out)
    |-> (m_data_tdata_out.overflow_flag == q.ovf))
    else $error("overflow flag differs from frame overflow state");

  a_index_step: assert property ((m_data_tvalid_out && m_data_tready_in && !m_data_tlast_out && !bitrev && en)
    |=> (m_data_tdata_out.output_bin_index
         == (($past(m_data_tdata_out.output_bin_index) + 16'h0001) & 16'(npts - 1'b1))))
    else $error("natural order bin index did not advance by one");

  a_inv_shift: assert property ((q.state == ST_BF && q.cfg.inverse_transform) |-> shift == 2'h1)
    else $error("inverse stage not halved");

endmodule

// File: rtl/sfft_twid.sv
// Iterative rotation engine producing one twiddle factor per request.
`timescale 1ns/10ps
module sfft_twid
  import sfft_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic start_in,
  input wire logic [MAX_LOG-1:0] angle_in,
  output sfft_cplx_t w_out,
  output logic done_out
);

  typedef struct packed {
    logic busy;
    logic done;
    logic neg;
    logic [3:0] it;
    logic signed [TW_W+1:0] x;
    logic signed [TW_W+1:0] y;
    logic [ANG_W-1:0] z;
    sfft_cplx_t w;
  } sfft_twid_st_t;

  sfft_twid_st_t q, d;
  logic [ANG_W-1:0] za;
  logic signed [TW_W+1:0] xs;
  logic signed [TW_W+1:0] ys;

  // Fold the angle into +-1/4 turn, then rotate one step per cycle.
  always_comb begin
    d = q;
    d.done = 1'b0;
    za = {angle_in, 8'h00};
    xs = q.x >>> q.it;
    ys = q.y >>> q.it;
    if (start_in && !q.busy) begin
      d.neg = za[ANG_W-1] ^ za[ANG_W-2];
      d.z = d.neg ? za + HALF_TURN : za;
      d.x = {2'b00, CORDIC_GAIN};
      d.y = '0;
      d.it = '0;
      d.busy = 1'b1;
    end else if (q.busy) begin
      if (!q.z[ANG_W-1]) begin
        d.x = q.x - ys;
        d.y = q.y + xs;
        d.z = q.z - ATAN_TAB[q.it];
      end else begin
        d.x = q.x + ys;
        d.y = q.y - xs;
        d.z = q.z + ATAN_TAB[q.it];
      end
      d.it = q.it + 4'h1;
      if (q.it == 4'(CORDIC_N - 1)) begin
        d.busy = 1'b0;
        d.done = 1'b1;
        d.w.re = q.neg ? -d.x[TW_W-1:0] : d.x[TW_W-1:0];
        d.w.im = q.neg ? -d.y[TW_W-1:0] : d.y[TW_W-1:0];
      end
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign w_out = q.w;
  assign done_out = q.done;

  // Each request finishes after a fixed number of rotation steps.
  a_twid_time: assert property (@(posedge mclk_in) disable iff (rst_in)
    (start_in && !q.busy) |-> ##15 done_out)
    else $error("twiddle not ready after fixed rotation count");

endmodule

// File: tb/sfft_core_test.sv
// Self-checking bench for the streaming transform core.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin mismatches++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module sfft_core_test
  import sfft_pkg::*;
;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic wb_req = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = '0;
  logic [31:0] wb_wdat = '0;
  logic [31:0] wb_rdat;
  logic wb_ack;
  logic cfg_v = 1'b0;
  sfft_cfg_t cfg_d = CFG_RST;
  logic cfg_rdy;
  logic d_v, d_rdy, m_v, m_last, m_rdy, irq;
  sfft_cplx_t d_dat;
  sfft_out_t m_dat;
  logic p_go = 1'b0;
  logic p_dc = 1'b0;
  logic p_slow = 1'b0;
  logic [15:0] p_amp = '0;
  int mismatches = 0;
  int check_count = 0;

  sfft_core u_sfft_core (.mclk_in(mclk_in), .rst_in(rst_in), .wb_cyc_in(wb_req), .wb_stb_in(wb_req),
    .wb_we_in(wb_we), .wb_adr_in(wb_adr), .wb_sel_in(4'hf), .wb_dat_in(wb_wdat), .wb_dat_out(wb_rdat),
    .wb_ack_out(wb_ack), .s_config_tvalid_in(cfg_v), .s_config_tdata_in(cfg_d),
    .s_config_tready_out(cfg_rdy), .s_data_tvalid_in(d_v), .s_data_tdata_in(d_dat),
    .s_data_tready_out(d_rdy), .m_data_tvalid_out(m_v), .m_data_tdata_out(m_dat),
    .m_data_tlast_out(m_last), .m_data_tready_in(m_rdy), .irq_out(irq));

  sfft_tb_peer u_sfft_tb_peer (.mclk_in(mclk_in), .go_in(p_go), .dc_in(p_dc), .slow_in(p_slow),
    .amp_in(p_amp), .s_data_tvalid_out(d_v), .s_data_tdata_out(d_dat), .s_data_tready_in(d_rdy),
    .m_data_tvalid_in(m_v), .m_data_tdata_in(m_dat), .m_data_tlast_in(m_last), .m_data_tready_out(m_rdy));

  // Free-running 100 MHz clock.
  initial begin
    forever #5 mclk_in = ~mclk_in;
  end

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // One classic bus cycle; the request is held until ack is sampled high, then released for a cycle.
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    wb_req <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_wdat <= d;
    // No cycle count is assumed; a slave that never answers is caught by the watchdog.
    do @(posedge mclk_in);
    while (wb_ack !== 1'b1);
    q = wb_rdat;
    wb_req <= 1'b0;
    @(posedge mclk_in);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input string nm);
    logic [31:0] q;
    wb(1'b0, a, '0, q);
    `CHK(nm, e, q & m)
  endtask

  // A configuration word is taken while the frame in flight keeps the old one.
  task automatic send_cfg(input logic inv, input logic [15:0] pl);
    cfg_v <= 1'b1;
    cfg_d <= '{scale_sch: 32'h0, inverse_transform: inv, nfft: 5'h3, prefix_length: pl};
    do @(posedge mclk_in);
    while (cfg_rdy !== 1'b1);
    cfg_v <= 1'b0;
    @(posedge mclk_in);
    #1 `CHK("cfg_ready", 1'b0, cfg_rdy)
  endtask

  // Runs one eight-point frame and judges every beat that comes out.
  task automatic frame(input logic [15:0] amp, input logic dc, slow, brv, input int pl,
                       input logic [15:0] er, input logic eo);
    int n;
    int idx;
    sfft_out_t b;
    n = 0;
    @(posedge mclk_in);
    p_go <= 1'b1;
    p_dc <= dc;
    p_slow <= slow;
    p_amp <= amp;
    @(posedge mclk_in);
    p_go <= 1'b0;
    // The sink count clears on this edge; an old count of the same size must not end the wait.
    do begin
      @(posedge mclk_in);
      n++;
    end while (u_sfft_tb_peer.rx_count != pl + 8 && n < 3000);
    repeat (4) @(posedge mclk_in);
    `CHK("beats", pl + 8, u_sfft_tb_peer.rx_count)
    for (int i = 0; i < pl + 8; i++) begin
      b = u_sfft_tb_peer.rx_data[i];
      idx = brv ? {i[0], i[1], i[2]} : (i < pl ? 8 - pl + i : i - pl);
      `CHK("bin", 16'(idx), b.output_bin_index)
      `CHK("last", (i == pl + 7), u_sfft_tb_peer.rx_last[i])
      `CHK("ovf", eo, b.overflow_flag)
      if (!dc) begin
        `CHK("re", er, b.data.re)
        `CHK("im", 16'h0000, b.data.im)
      end
    end
  endtask

  // Watchdog sized well above four short frames.
  initial begin
    repeat (40000) @(posedge mclk_in);
    mismatches++;
    report_and_stop();
  end

  // Main sequence.
  initial begin
    logic [31:0] q;
    repeat (2) @(posedge mclk_in);
    rst_in <= 1'b0;
    @(posedge mclk_in);
    rd(REG_CTRL, CTRL_RST, 32'h3, "ctrl");
    rd(REG_MASK, MASK_RST, 32'h7, "mask");
    wb(1'b1, 8'h0c, 32'h5, q);
    rd(8'h0c, 32'h0, 32'hffffffff, "unmapped");
    send_cfg(1'b1, 16'h0002);
    frame(16'h0400, 1'b0, 1'b0, 1'b0, 0, 16'h0400, 1'b0);
    rd(REG_STATUS, 32'h5, 32'h7, "status1");
    `CHK("irq_masked", 1'b0, irq)
    send_cfg(1'b0, 16'h0000);
    frame(16'h0800, 1'b0, 1'b1, 1'b0, 2, 16'h0100, 1'b0);
    rd(REG_STATUS, 32'h5, 32'h7, "status2");
    wb(1'b1, REG_MASK, 32'h2, q);
    rd(REG_MASK, 32'h2, 32'h7, "mask2");
    frame(16'h7fff, 1'b1, 1'b0, 1'b0, 0, 16'h0000, 1'b1);
    `CHK("irq_set", 1'b1, irq)
    rd(REG_STATUS, 32'h3, 32'h3, "status3");
    `CHK("irq_clr", 1'b0, irq)
    wb(1'b1, REG_CTRL, 32'h3, q);
    frame(16'h0400, 1'b0, 1'b1, 1'b1, 0, 16'h0400, 1'b0);
    report_and_stop();
  end
endmodule

// File: tb/sfft_tb_peer.sv
// Stream partner: impulse or constant source upstream and a stalling sink downstream.
`timescale 1ns/10ps
module sfft_tb_peer
  import sfft_pkg::*;
(
  input wire logic mclk_in,
  input wire logic go_in,
  input wire logic dc_in,
  input wire logic slow_in,
  input wire logic [DATA_W-1:0] amp_in,
  output logic s_data_tvalid_out,
  output sfft_cplx_t s_data_tdata_out,
  input wire logic s_data_tready_in,
  input wire logic m_data_tvalid_in,
  input wire sfft_out_t m_data_tdata_in,
  input wire logic m_data_tlast_in,
  output logic m_data_tready_out
);
  int sent = 0;
  int rx_count = 0;
  sfft_cplx_t src_q = '0;
  sfft_out_t rx_data [32];
  logic rx_last [32];

  // An idle data line shows the inverse of its last value, so a stale sample is never taken for a good one.
  assign s_data_tdata_out = s_data_tvalid_out ? src_q : ~src_q;

  initial begin
    s_data_tvalid_out = 1'b0;
    m_data_tready_out = 1'b1;
  end

  // Eight beats per frame; each beat is held until the core takes it.
  always @(posedge mclk_in) begin
    if (go_in) begin
      sent <= 0;
      s_data_tvalid_out <= 1'b1;
      src_q <= '{re: amp_in, im: '0};
    end else if (s_data_tvalid_out && s_data_tready_in) begin
      sent <= sent + 1;
      s_data_tvalid_out <= (sent != 7);
      src_q <= '{re: (dc_in ? amp_in : '0), im: '0};
    end
  end

  // The sink stalls every other cycle when slow, and records each accepted beat.
  always @(posedge mclk_in) begin
    m_data_tready_out <= slow_in ? ~m_data_tready_out : 1'b1;
    if (go_in) begin
      rx_count <= 0;
    end else if (m_data_tvalid_in && m_data_tready_out && rx_count < 32) begin
      rx_data[rx_count] <= m_data_tdata_in;
      rx_last[rx_count] <= m_data_tlast_in;
      rx_count <= rx_count + 1;
    end
  end
endmodule
